/* rtl/rtc_trim_pkg.sv */
// Shared constants for the carry-lock and rate-trim time-keeping core.
package rtc_trim_pkg;
  // Register addresses on the serial link.
  localparam logic [3:0] ADDR_SECONDS = 4'h0;
  localparam logic [3:0] ADDR_TRIM    = 4'h7;
  localparam logic [3:0] ADDR_CTRL1   = 4'hE;
  localparam logic [3:0] ADDR_CTRL2   = 4'hF;
  // Field positions.
  localparam int         POWER_UP_FLAG_BIT = 4;
  localparam int         FMT_READ_BIT = 2;
  localparam int         FMT_ONE_BIT  = 3;
  // Values after reset.
  localparam logic [6:0] TRIM_RESET   = 7'h00;
  localparam logic [2:0] CTRL1_RESET  = 3'h0;
  localparam logic [7:0] SEC_RESET    = 8'h00;
  // Periodic select code giving the 1 Hz pulse on the interrupt pin.
  localparam logic [2:0] PULSE_1HZ    = 3'h3;
  // Crystal ticks in one nominal second and index of the last second in a trim window.
  localparam int         TICKS_PER_SEC = 32768;
  localparam logic [4:0] TRIM_WINDOW_LAST = 5'h13;
  // Each trim step moves the trimmed second by this many crystal ticks.
  localparam int         TICKS_PER_STEP = 2;
  localparam logic [7:0] SEC_WRAP     = 8'h59;
endpackage

/* rtl/rtc_serial_link.sv */
// Serial slave on the host's shift clock: command byte, then data bytes.
`timescale 1ns/10ps
module rtc_serial_link
  import rtc_trim_pkg::*;
(
  // Reset and link pins
  input  wire logic       nrst,
  input  wire logic       sclk,
  input  wire logic       ce,
  input  wire logic       si,
  output logic            so,
  output logic            so_oe,
  // Register access toward the core
  output logic [3:0]      rd_addr,
  input  wire logic [7:0] rd_data,
  output logic            wr_toggle,
  output logic [3:0]      wr_addr,
  output logic [7:0]      wr_data
);
  // The frame's own enable ends every session; the shift clock may stop.
  logic       frame_rst_n;
  logic [2:0] bit_q;
  logic [6:0] shift_q;
  logic       data_phase_q;
  logic [3:0] addr_q;
  logic [3:0] fmt_q;
  logic [7:0] byte_in;
  logic       reading;

  assign frame_rst_n = nrst & ce;
  assign byte_in     = {shift_q, si};
  assign reading     = data_phase_q & fmt_q[FMT_READ_BIT];
  assign rd_addr     = addr_q;

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_q   <= 3'h0;
      shift_q <= 7'h00;
    end else begin
      bit_q   <= bit_q + 3'h1;
      shift_q <= byte_in[6:0];
    end
  end

  // Address nibble then format nibble, MSB first
  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      data_phase_q <= 1'b0;
      addr_q       <= 4'h0;
      fmt_q        <= 4'h0;
    end else if (bit_q == 3'h7) begin
      if (!data_phase_q) begin
        addr_q       <= byte_in[7:4];
        fmt_q        <= byte_in[3:0];
        data_phase_q <= 1'b1;
      end else if (fmt_q[FMT_ONE_BIT]) begin
        data_phase_q <= 1'b0;
      end else begin
        addr_q <= addr_q + 4'h1;
      end
    end
  end

  // The toggle survives the frame end so no write event is faked.
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      wr_toggle <= 1'b0;
      wr_addr   <= 4'h0;
      wr_data   <= 8'h00;
    end else if (ce && bit_q == 3'h7 && data_phase_q && !fmt_q[FMT_READ_BIT]) begin
      wr_toggle <= ~wr_toggle;
      wr_addr   <= addr_q;
      wr_data   <= byte_in;
    end
  end

  always_ff @(negedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      so    <= 1'b0;
      so_oe <= 1'b0;
    end else begin
      so    <= rd_data[3'h7 - bit_q];
      so_oe <= reading;
    end
  end
endmodule

/* rtl/rtc_carry_lock_and_rate_trim.sv */
// Time-keeping core: seconds carry lock during link sessions and rate trim.
//
// Contract
// - Hold any seconds carry while enable is high; apply it when enable falls. Only the first is held; later second ends advance the seconds.
// - A held seconds carry can be kept pending for one second at most.
// - Trim changes the length of one second in each twenty seconds.
// - Trim is off when the six low bits of the trim value are zero.
// - Codes 00h, 01h, 40h and 41h apply no correction.
// - Codes 02h to 3Fh lengthen the trimmed second by code minus one steps.
// - Codes 42h to 7Fh shorten the trimmed second by 80h minus code steps.
// - Crystal clock output keeps the raw crystal rate whatever the trim.
// - Crystal clock output runs from power-on without configuration.
// - Select code 011 in control register 1 gives a 1 Hz pulse output.
// - Only one 1 Hz period in twenty is changed by the trim.
// - Frames run from enable rise to fall; address, format, MSB first.
// - Power-up sets the power-up flag and clears the trim value.
`timescale 1ns/10ps
module rtc_carry_lock_and_rate_trim
  import rtc_trim_pkg::*;
#(
  parameter int ticks_per_sec = TICKS_PER_SEC
)
(
  // Core clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Crystal input and open-drain crystal clock output
  input  wire logic xtal_in,
  output logic      crystal_clock_out,
  output logic      crystal_clock_out_oe,
  // Serial link from the host
  input  wire logic sclk,
  input  wire logic ce,
  input  wire logic si,
  output logic      so,
  output logic      so_oe,
  // Open-drain interrupt pin
  output logic      interrupt_out_n,
  output logic      interrupt_out_n_oe
);
  localparam logic [15:0] NOMINAL_M1 = 16'(ticks_per_sec - 1);
  localparam logic [15:0] HALF_TICKS = 16'(ticks_per_sec / 2);

  // Signed tick adjustment for the trimmed second.
  function automatic logic signed [7:0] trim_ticks(input logic [6:0] code);
    logic signed [7:0] adj;
    adj = 8'sh00;
    if (code[5:0] == 6'h00 || code[5:0] == 6'h01) begin
      adj = 8'sh00;
    end else if (!code[6]) begin
      adj = 8'(TICKS_PER_STEP * (int'(code) - 1));
    end else begin
      adj = 8'(-TICKS_PER_STEP * (128 - int'(code)));
    end
    return adj;
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    if (v == SEC_WRAP) begin
      r = 8'h00;
    end else if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // Synchronisers: bit 0 enable, bit 1 crystal, bit 2 write toggle.
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       xtal_d_q;
  logic       wtog_d_q;
  logic       ce_s;
  logic       xtal_rise;
  logic       wr_event;

  logic [3:0] rd_addr;
  logic [7:0] rd_data;
  logic       wr_toggle;
  logic [3:0] wr_addr;
  logic [7:0] wr_data;

  logic [15:0]       presc_q;
  logic [4:0]        win_q;
  logic [7:0]        sec_q;
  logic              pend_q;
  logic [6:0]        trim_q;
  logic [2:0]        ctrl1_q;
  logic              power_up_flag_q;
  logic signed [7:0] trim_adj;
  logic [15:0]       plen_m1;
  logic              sec_tick;
  logic              wr_sec;

  rtc_serial_link rtc_serial_link_inst (
    .nrst      (nrst),
    .sclk      (sclk),
    .ce        (ce),
    .si        (si),
    .so        (so),
    .so_oe     (so_oe),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .wr_toggle (wr_toggle),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q  <= 3'h0;
      sync2_q  <= 3'h0;
      xtal_d_q <= 1'b0;
      wtog_d_q <= 1'b0;
    end else begin
      sync1_q  <= {wr_toggle, xtal_in, ce};
      sync2_q  <= sync1_q;
      xtal_d_q <= sync2_q[1];
      wtog_d_q <= sync2_q[2];
    end
  end

  assign ce_s      = sync2_q[0];
  assign xtal_rise = sync2_q[1] & ~xtal_d_q;
  assign wr_event  = sync2_q[2] ^ wtog_d_q;
  // Write address and data stand for a whole byte time, far longer than the sync delay.
  assign wr_sec    = wr_event && wr_addr == ADDR_SECONDS;

  // Raw crystal straight to the pin, untouched by trim, live from reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      crystal_clock_out_oe <= 1'b0;
    end else begin
      crystal_clock_out_oe <= ~sync2_q[1];
    end
  end
  assign crystal_clock_out = 1'b0;

  // Only the last second of each window is stretched or shortened
  assign trim_adj = trim_ticks(trim_q);
  assign plen_m1  = (win_q == TRIM_WINDOW_LAST) ? NOMINAL_M1 + 16'(trim_adj) : NOMINAL_M1;
  // Ending on reaching or passing the length keeps a trim shortened mid-second from stalling the count.
  assign sec_tick = xtal_rise && presc_q >= plen_m1;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      presc_q <= 16'h0000;
    end else if (sec_tick) begin
      presc_q <= 16'h0000;
    end else if (xtal_rise) begin
      presc_q <= presc_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      win_q <= 5'h00;
    end else if (sec_tick) begin
      win_q <= (win_q == TRIM_WINDOW_LAST) ? 5'h00 : win_q + 5'h01;
    end
  end

  // A single pending carry: the lock covers one second only
  // A carry that meets a seconds write in the same cycle is still held and lands on the new value.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 1'b0;
    end else if (sec_tick && ce_s) begin
      pend_q <= 1'b1;
    end else if (!ce_s || wr_sec) begin
      pend_q <= 1'b0;
    end
  end

  // Seconds stay frozen through one second end in a session so reads agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sec_q <= SEC_RESET;
    end else if (wr_sec) begin
      sec_q <= {1'b0, wr_data[6:0]};
    end else if (sec_tick && ce_s && pend_q) begin
      sec_q <= bcd_inc(sec_q);
    end else if (sec_tick && !ce_s && pend_q) begin
      // A release that meets a new second end owes two increments, not one.
      sec_q <= bcd_inc(bcd_inc(sec_q));
    end else if ((sec_tick && !ce_s) || (pend_q && !ce_s)) begin
      sec_q <= bcd_inc(sec_q);
    end
  end

  // Trim and control are cleared and the flag raised at power-up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trim_q  <= TRIM_RESET;
      ctrl1_q <= CTRL1_RESET;
    end else if (wr_event && wr_addr == ADDR_TRIM) begin
      trim_q <= wr_data[6:0];
    end else if (wr_event && wr_addr == ADDR_CTRL1) begin
      ctrl1_q <= wr_data[2:0];
    end
  end

  // The flag only accepts a write of zero.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      power_up_flag_q <= 1'b1;
    end else if (wr_event && wr_addr == ADDR_CTRL2 && !wr_data[POWER_UP_FLAG_BIT]) begin
      power_up_flag_q <= 1'b0;
    end
  end

  // 1 Hz pulse, low for the first HALF_TICKS crystal ticks of every second, trimmed or not
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_out_n_oe <= 1'b0;
    end else begin
      interrupt_out_n_oe <= (ctrl1_q == PULSE_1HZ) && (presc_q < HALF_TICKS);
    end
  end
  assign interrupt_out_n = 1'b0;

  // The link reads these across domains; they hold still while a session under one second is
  // open because the carry is locked, which is why the host waits after enable.
  always_comb begin
    case (rd_addr)
      ADDR_SECONDS: rd_data = sec_q;
      ADDR_TRIM:    rd_data = {1'b0, trim_q};
      ADDR_CTRL1:   rd_data = {5'h00, ctrl1_q};
      ADDR_CTRL2:   rd_data = 8'(power_up_flag_q) << POWER_UP_FLAG_BIT;
      default:      rd_data = 8'h00;
    endcase
  end

  lock_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    sec_tick && ce_s && !pend_q && !wr_sec |=> pend_q && sec_q == $past(sec_q))
    else $error("seconds moved while locked");

  release_a: assert property (@(posedge clk) disable iff (!nrst)
    pend_q && !ce_s && !wr_sec && !sec_tick |=> sec_q == bcd_inc($past(sec_q)) && !pend_q)
    else $error("held carry not applied at release");

  release_tick_a: assert property (@(posedge clk) disable iff (!nrst)
    pend_q && !ce_s && !wr_sec && sec_tick |=> sec_q == bcd_inc(bcd_inc($past(sec_q))) && !pend_q)
    else $error("carry lost when release meets a second end");

  overrun_a: assert property (@(posedge clk) disable iff (!nrst)
    sec_tick && ce_s && pend_q && !wr_sec |=> sec_q == bcd_inc($past(sec_q)) && pend_q)
    else $error("second lost in long session");

  trim_none_a: assert property (@(posedge clk) disable iff (!nrst)
    trim_q == 7'h00 || trim_q == 7'h01 || trim_q == 7'h40 || trim_q == 7'h41
    |-> plen_m1 == NOMINAL_M1)
    else $error("neutral code changes period");

  trim_off_a: assert property (@(posedge clk) disable iff (!nrst)
    trim_q[5:0] == 6'h00 |-> trim_adj == 8'sh00)
    else $error("trim active with zero low bits");

  trim_gain_a: assert property (@(posedge clk) disable iff (!nrst)
    !trim_q[6] && trim_q[5:1] != 5'h00 |-> trim_adj == 8'(2 * (int'(trim_q) - 1)))
    else $error("gain step wrong");

  trim_loss_a: assert property (@(posedge clk) disable iff (!nrst)
    trim_q[6] && trim_q[5:1] != 5'h00 |-> trim_adj == 8'(-2 * (128 - int'(trim_q))))
    else $error("loss step wrong");

  one_in_twenty_a: assert property (@(posedge clk) disable iff (!nrst)
    sec_tick && win_q != TRIM_WINDOW_LAST |-> presc_q == NOMINAL_M1)
    else $error("untrimmed second has wrong length");

  xtal_pass_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(sync2_q[1]) |=> !crystal_clock_out_oe)
    else $error("crystal output not released on crystal high");

  xtal_low_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(sync2_q[1]) |=> crystal_clock_out_oe)
    else $error("crystal output not pulled low on crystal low");

  pulse_off_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl1_q != PULSE_1HZ || presc_q >= HALF_TICKS |=> !interrupt_out_n_oe)
    else $error("pulse low outside first half of second");

  pulse_out_a: assert property (@(posedge clk) disable iff (!nrst)
    ctrl1_q == PULSE_1HZ && $past(ctrl1_q) == PULSE_1HZ && sec_tick ##1 1
    |=> interrupt_out_n_oe)
    else $error("no pulse at start of second");

  power_up_a: assert property (@(posedge clk)
    $rose(nrst) |-> power_up_flag_q && trim_q == TRIM_RESET)
    else $error("power-up values wrong");
endmodule

/* verification/rtc_host_model.sv */
// Host model that drives the serial link of the time-keeping core.
`timescale 1ns/10ps
module rtc_host_model #(
  parameter int half_ns  = 16,
  parameter int setup_ns = 200,
  parameter int low_ns   = 400
) (
  // Link pins
  output logic      sclk,
  output logic      ce,
  output logic      si,
  input  wire logic so
);
  // The shift clock rests high between frames, which selects sampling on the rising edge.
  initial begin
    sclk = 1'b1;
    ce   = 1'b0;
    si   = 1'b0;
  end

  // Enable stays high without a break until frame_end, and time data waits out the carry settle.
  task automatic frame_begin;
    ce = 1'b1;
    #(setup_ns);
  endtask

  // The low gap lets a held carry land before the next frame.
  task automatic frame_end;
    ce = 1'b0;
    #(low_ns);
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sclk = 1'b0;
      si   = tx[i];
      #(half_ns);
      sclk  = 1'b1;
      rx[i] = so;
      #(half_ns);
    end
  endtask

  // One register per frame keeps each session well under one second of core time.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    frame_begin();
    xfer({a, 4'h8}, dummy);
    xfer(d, dummy);
    frame_end();
  endtask

  // Burst frames step the address after each data byte.
  task automatic wr_burst(input logic [3:0] a, input logic [7:0] d0, input logic [7:0] d1);
    logic [7:0] dummy;
    frame_begin();
    xfer({a, 4'h0}, dummy);
    xfer(d0, dummy);
    xfer(d1, dummy);
    frame_end();
  endtask

  task automatic rd_burst(input logic [3:0] a, output logic [7:0] d0, output logic [7:0] d1);
    logic [7:0] dummy;
    frame_begin();
    xfer({a, 4'h4}, dummy);
    xfer(8'h00, d0);
    xfer(8'h00, d1);
    frame_end();
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    logic [7:0] dummy;
    frame_begin();
    xfer({a, 4'hC}, dummy);
    xfer(8'h00, d);
    frame_end();
  endtask
endmodule

/* verification/rtc_carry_lock_and_rate_trim_test.sv */
// Self-checking bench for the carry-lock and rate-trim core.
`timescale 1ns/10ps
module rtc_carry_lock_and_rate_trim_test
  import rtc_trim_pkg::*;
;
  localparam int tps = 32;
  logic       clk        = 1'b0;
  logic       nrst       = 1'b0;
  logic       xtal_in    = 1'b0;
  logic       sclk;
  logic       ce;
  logic       si;
  logic       so;
  logic       so_oe;
  logic       so_last    = 1'b0;
  logic       so_pin;
  logic       ck_out;
  logic       ck_oe;
  logic       irq_n;
  logic       irq_oe;
  logic [7:0] d;
  int         n_mismatch = 0;
  int         n_compared = 0;

  always #2.5 clk = ~clk;
  always #50 xtal_in = ~xtal_in;
  // A released data-out line shows a toggling pattern, never the last driven bit.
  assign so_pin = so_oe ? so : ~so_last;
  always @(negedge sclk) so_last <= so_pin;

  rtc_carry_lock_and_rate_trim #(.ticks_per_sec(tps)) rtc_carry_lock_and_rate_trim_inst (
    .clk(clk), .nrst(nrst), .xtal_in(xtal_in), .crystal_clock_out(ck_out),
    .crystal_clock_out_oe(ck_oe), .sclk(sclk), .ce(ce), .si(si), .so(so), .so_oe(so_oe),
    .interrupt_out_n(irq_n), .interrupt_out_n_oe(irq_oe));
  rtc_host_model rtc_host_model_inst (.sclk(sclk), .ce(ce), .si(si), .so(so_pin));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v == SEC_WRAP) ? 8'h00 : (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // Samples both crystal phases; the crystal output must pass the raw crystal through.
  task automatic tick_sample(output logic v);
    @(posedge xtal_in);
    #30;
    v = irq_oe;
    check({irq_n, ck_out, ck_oe}, 16'h0000);
    @(negedge xtal_in);
    #30;
    check({irq_n, ck_out, ck_oe}, 16'h0001);
  endtask

  // Counts crystal ticks until the next rise of the 1 Hz pulse.
  task automatic next_rise(output int n);
    logic v;
    logic prev;
    prev = 1'b1;
    n    = 0;
    for (int i = 0; i < 400; i++) begin
      tick_sample(v);
      n++;
      if (v && !prev) return;
      prev = v;
    end
    n_mismatch++;
    $display("[FAIL] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    wrap_up();
  endtask

  task automatic test_reset_regs;
    logic [7:0] d2;
    tick_sample(d[0]);
    check(irq_oe, 1'b0);
    rtc_host_model_inst.rd(ADDR_TRIM, d);
    check(d, 8'h00);
    rtc_host_model_inst.rd(ADDR_CTRL2, d);
    check(d & 8'h10, 8'h10);
    rtc_host_model_inst.rd(4'h5, d);
    check(d, 8'h00);
    rtc_host_model_inst.wr(ADDR_TRIM, 8'h89);
    rtc_host_model_inst.rd(ADDR_TRIM, d);
    check(d, 8'h09);
    rtc_host_model_inst.wr(ADDR_CTRL2, 8'h00);
    rtc_host_model_inst.rd(ADDR_CTRL2, d);
    check(d, 8'h00);
    rtc_host_model_inst.wr(ADDR_CTRL1, 8'h03);
    rtc_host_model_inst.rd(ADDR_CTRL1, d);
    check(d, 8'h03);
    rtc_host_model_inst.wr_burst(4'h6, 8'h00, 8'h0A);
    rtc_host_model_inst.rd(ADDR_TRIM, d);
    check(d, 8'h0A);
    rtc_host_model_inst.rd_burst(ADDR_CTRL1, d, d2);
    check(d, 8'h03);
    check(d2, 8'h00);
    $display("test reset_regs done");
  endtask

  // Twenty consecutive 1 Hz periods hold exactly one trimmed second, or none for a neutral code.
  task automatic test_trim(input logic [7:0] code, input int adj);
    int n;
    int sum;
    int nom;
    rtc_host_model_inst.wr(ADDR_TRIM, code);
    next_rise(n);
    sum = 0;
    nom = 0;
    repeat (20) begin
      next_rise(n);
      sum += n;
      if (n == tps) nom++;
    end
    check(16'(sum), 16'(20 * tps + adj));
    check(16'(nom), (adj == 0) ? 16'h0014 : 16'h0013);
    $display("test trim %h done", code);
  endtask

  // Enable is held across one or two second ends, then released.
  task automatic test_carry(input int hold_ticks, input int held_incs);
    int         n;
    logic [7:0] e;
    next_rise(n);
    rtc_host_model_inst.rd(ADDR_SECONDS, e);
    rtc_host_model_inst.frame_begin();
    repeat (hold_ticks) @(posedge xtal_in);
    rtc_host_model_inst.xfer({ADDR_SECONDS, 4'hC}, d);
    rtc_host_model_inst.xfer(8'h00, d);
    repeat (held_incs) e = bcd_inc(e);
    check(d, e);
    rtc_host_model_inst.frame_end();
    rtc_host_model_inst.rd(ADDR_SECONDS, d);
    check(d, bcd_inc(e));
    $display("test carry %0d done", hold_ticks);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    test_reset_regs();
    test_trim(8'h41, 0);
    test_trim(8'h40, 0);
    test_trim(8'h09, 16);
    test_trim(8'h7C, -8);
    rtc_host_model_inst.wr(ADDR_TRIM, 8'h00);
    rtc_host_model_inst.wr(ADDR_SECONDS, 8'h05);
    test_carry(28, 0);
    test_carry(60, 1);
    wrap_up();
  end
endmodule
